// ---- rtl/start_identifier_pkg.sv ----
// shared constants and carrier types for the start identifier matcher
`default_nettype none
package start_identifier_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_FIRST_LEN   = 10'h04e;
  localparam logic [9:0] IDX_SECOND_LEN  = 10'h04f;
  localparam logic [9:0] IDX_GAP         = 10'h050;
  localparam logic [9:0] IDX_FIRST_LO    = 10'h051;
  localparam logic [9:0] IDX_FIRST_HI    = 10'h052;
  localparam logic [9:0] IDX_SECOND_LO   = 10'h053;
  localparam logic [9:0] IDX_SECOND_HI   = 10'h054;
  localparam logic [9:0] IDX_MSG_END     = 10'h055;
  localparam logic [9:0] IDX_PAYLOAD_LEN = 10'h056;
  localparam logic [9:0] IDX_SCHEME      = 10'h04d;
  localparam logic [9:0] IDX_STATUS      = 10'h05f;

  // field layout
  localparam int LEN_W         = 5;
  localparam int COARSE_MSB    = 7;
  localparam int COARSE_LSB    = 3;
  localparam int FINE_MSB      = 2;
  localparam int END_SYNC_BIT  = 2;
  localparam int END_CV_BIT    = 1;
  localparam int END_LEN_BIT   = 0;
  localparam int RESYNC_BIT    = 7;
  localparam logic [4:0] FULL_LEN = 5'h10;

  // reset values and the bit count meant by a zero payload length
  localparam logic [7:0] MSG_END_RESET = 8'h05;
  localparam logic [7:0] SCHEME_RESET  = 8'h80;
  localparam logic [8:0] LEN_ZERO_BITS = 9'h100;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SCHEME_SEQ16    = 2'h0,
    SCHEME_PARALLEL = 2'h1,
    SCHEME_GAP      = 2'h2,
    SCHEME_EXTENDED = 2'h3
  } scheme_t;

  typedef enum logic [3:0] {
    ST_HUNT    = 4'h1,
    ST_GAP     = 4'h2,
    ST_SECOND  = 4'h4,
    ST_PAYLOAD = 4'h8
  } state_t;

  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;
endpackage
`default_nettype wire

// ---- rtl/chip_pattern_compare.sv ----
// compares the newest received chips with one reference pattern
`default_nettype none
module chip_pattern_compare #(
  parameter int CHIPS = 16
) (
  // reference
  input  wire logic [CHIPS-1:0] pattern,
  input  wire logic [4:0]       patternLen,
  // stream history, chip 0 newest
  input  wire logic [CHIPS-1:0] history,
  // result
  output logic                  match
);
  logic [CHIPS-1:0] mask;

  always_comb begin
    // lengths above full are unused and treated as full
    if (patternLen >= 5'(CHIPS)) begin
      mask = '1;
    end else begin
      mask = (CHIPS'(1) << patternLen) - CHIPS'(1);
    end
    match = (patternLen != 5'h00) && (((history ^ pattern) & mask) == '0);
  end
endmodule
`default_nettype wire

// ---- rtl/start_pattern_match_eom_cfg.sv ----
// start identifier matcher with message end criteria and register slave
// Behaviour
// - first pattern length is five bits, 1 to 16 chips, above 16 unused
// - second pattern length up to 16; zero allowed only in 16-bit scheme
// - coarse gap bits 7:3 in half-bit steps, 1f is fifteen and half
// - gap scheme: coarse gap relocks bit recovery between first and second
// - fine gap bits 2:0 in sixteenth-bit steps, up to seven sixteenths
// - resync disabled: fine gap corrects oscillator phase after coarse gap
// - each pattern in two bytes, low byte chips 7:0, high byte 15:8
// - end enables: sync loss on, code violation off, length on at reset
// - two-bit scheme: seq B then A, parallel, gap, parallel with match bit
// - 16-bit scheme evaluates B only with A length 16 and B length nonzero
// - payload bits counted after identifier; zero count means 256 bits
//
// The implementer's own choice: the AXI4-Lite register port.
`default_nettype none
module start_pattern_match_eom_cfg #(
  parameter int CHIPS = 16
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // register bus
  input  wire start_identifier_pkg::axi_req_t axiReq,
  output var start_identifier_pkg::axi_rsp_t  axiRsp,
  // recovered chip stream
  input  wire logic                          chipValid,
  input  wire logic                          chipData,
  input  wire logic                          syncLoss,
  input  wire logic                          codeViolation,
  // matcher results
  output logic                               identifierFound,
  output logic                               secondWasMatched,
  output logic                               relockPll,
  output logic                               phaseCorrect,
  output logic [2:0]                         phaseStep,
  output logic                               payloadValid,
  output logic                               payloadBit,
  output logic                               messageEnd
);
  import start_identifier_pkg::*;
  //////////////////////////////////////////////////////////////////////////
  logic [LEN_W-1:0] firstLen_reg;
  logic [LEN_W-1:0] secondLen_reg;
  logic [7:0]       gap_reg;
  logic [7:0]       firstLo_reg;
  logic [7:0]       firstHi_reg;
  logic [7:0]       secondLo_reg;
  logic [7:0]       secondHi_reg;
  logic [2:0]       msgEnd_reg;
  logic [7:0]       payloadLen_reg;
  logic [7:0]       scheme_reg;
  logic             awReady_reg;
  logic             wReady_reg;
  logic             arReady_reg;
  logic [9:0]       awIdx_reg;
  logic [7:0]       wByte_reg;
  logic             wLane_reg;
  logic             bvalid_reg;
  logic [1:0]       bresp_reg;
  logic             rvalid_reg;
  logic [31:0]      rdata_reg;
  logic [1:0]       rresp_reg;
  state_t           state_reg;
  logic [CHIPS-1:0] history_reg;
  logic [4:0]       chipCnt_reg;
  logic [8:0]       bitCnt_reg;
  logic             chipPhase_reg;
  logic             firstIsB_reg;
  logic             doWrite;
  logic [CHIPS-1:0] historyNext;
  logic [CHIPS-1:0] patA;
  logic [CHIPS-1:0] patB;
  logic             matchA;
  logic             matchB;
  scheme_t          scheme;
  logic             bEnabled16;
  logic [4:0]       coarseGap;
  logic [8:0]       lengthLimit;
  logic             endEvent;
  //////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: address and data taken in either order
  assign axiRsp.awready = awReady_reg;
  assign axiRsp.wready  = wReady_reg;
  assign axiRsp.bvalid  = bvalid_reg;
  assign axiRsp.bresp   = bresp_reg;
  assign axiRsp.arready = arReady_reg;
  assign axiRsp.rvalid  = rvalid_reg;
  assign axiRsp.rdata   = rdata_reg;
  assign axiRsp.rresp   = rresp_reg;
  assign doWrite = !awReady_reg && !wReady_reg && !bvalid_reg;
  function automatic logic known(input logic [9:0] idx);
    known = (idx >= IDX_SCHEME && idx <= IDX_PAYLOAD_LEN) || idx == IDX_STATUS;
  endfunction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awReady_reg <= 1'b1;
      wReady_reg  <= 1'b1;
      awIdx_reg   <= 10'h000;
      wByte_reg   <= 8'h00;
      wLane_reg   <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (axiReq.awvalid && awReady_reg) begin
        awReady_reg <= 1'b0;
        awIdx_reg   <= axiReq.awaddr[11:2];
      end
      if (axiReq.wvalid && wReady_reg) begin
        wReady_reg <= 1'b0;
        wByte_reg  <= axiReq.wdata[7:0];
        wLane_reg  <= axiReq.wstrb[0];
      end
      if (doWrite) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= (known(awIdx_reg) && awIdx_reg != IDX_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && axiReq.bready) begin
        bvalid_reg  <= 1'b0;
        awReady_reg <= 1'b1;
        wReady_reg  <= 1'b1;
      end
    end
  end
  // register file; only byte lane 0 carries data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      firstLen_reg   <= '0;
      secondLen_reg  <= '0;
      gap_reg        <= 8'h00;
      firstLo_reg    <= 8'h00;
      firstHi_reg    <= 8'h00;
      secondLo_reg   <= 8'h00;
      secondHi_reg   <= 8'h00;
      msgEnd_reg     <= MSG_END_RESET[2:0];
      payloadLen_reg <= 8'h00;
      scheme_reg     <= SCHEME_RESET;
    end else if (doWrite && wLane_reg) begin
      case (awIdx_reg)
        IDX_FIRST_LEN:   firstLen_reg   <= wByte_reg[LEN_W-1:0];
        IDX_SECOND_LEN:  secondLen_reg  <= wByte_reg[LEN_W-1:0];
        IDX_GAP:         gap_reg        <= wByte_reg;
        IDX_FIRST_LO:    firstLo_reg    <= wByte_reg;
        IDX_FIRST_HI:    firstHi_reg    <= wByte_reg;
        IDX_SECOND_LO:   secondLo_reg   <= wByte_reg;
        IDX_SECOND_HI:   secondHi_reg   <= wByte_reg;
        IDX_MSG_END:     msgEnd_reg     <= wByte_reg[2:0];
        IDX_PAYLOAD_LEN: payloadLen_reg <= wByte_reg;
        IDX_SCHEME:      scheme_reg     <= wByte_reg;
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_reg  <= 1'b0;
      arReady_reg <= 1'b1;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= RESP_OKAY;
    end else if (axiReq.arvalid && arReady_reg) begin
      rvalid_reg  <= 1'b1;
      arReady_reg <= 1'b0;
      rresp_reg  <= known(axiReq.araddr[11:2]) ? RESP_OKAY : RESP_SLVERR;
      case (axiReq.araddr[11:2])
        IDX_FIRST_LEN:   rdata_reg <= {27'h0000000, firstLen_reg};
        IDX_SECOND_LEN:  rdata_reg <= {27'h0000000, secondLen_reg};
        IDX_GAP:         rdata_reg <= {24'h000000, gap_reg};
        IDX_FIRST_LO:    rdata_reg <= {24'h000000, firstLo_reg};
        IDX_FIRST_HI:    rdata_reg <= {24'h000000, firstHi_reg};
        IDX_SECOND_LO:   rdata_reg <= {24'h000000, secondLo_reg};
        IDX_SECOND_HI:   rdata_reg <= {24'h000000, secondHi_reg};
        IDX_MSG_END:     rdata_reg <= {29'h00000000, msgEnd_reg};
        IDX_PAYLOAD_LEN: rdata_reg <= {24'h000000, payloadLen_reg};
        IDX_SCHEME:      rdata_reg <= {24'h000000, scheme_reg};
        IDX_STATUS:      rdata_reg <= {15'h0000, bitCnt_reg, firstIsB_reg, 3'h0, state_reg};
        default:         rdata_reg <= 32'h00000000;
      endcase
    end else if (rvalid_reg && axiReq.rready) begin
      rvalid_reg  <= 1'b0;
      arReady_reg <= 1'b1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // pattern comparison
  assign patA        = {firstHi_reg, firstLo_reg};
  assign patB        = {secondHi_reg, secondLo_reg};
  assign historyNext = {history_reg[CHIPS-2:0], chipData};
  assign scheme      = scheme_t'(scheme_reg[1:0]);
  assign coarseGap   = gap_reg[COARSE_MSB:COARSE_LSB];
  assign bEnabled16  = (firstLen_reg == FULL_LEN) && (secondLen_reg != 5'h00);
  assign lengthLimit = (payloadLen_reg == 8'h00) ? LEN_ZERO_BITS : {1'b0, payloadLen_reg};
  assign endEvent    = (msgEnd_reg[END_SYNC_BIT] && syncLoss)
                     || (msgEnd_reg[END_CV_BIT] && codeViolation);
  chip_pattern_compare #(
    .CHIPS      (CHIPS)
  ) compareA (
    .pattern    (patA),
    .patternLen (firstLen_reg),
    .history    (historyNext),
    .match      (matchA)
  );
  chip_pattern_compare #(
    .CHIPS      (CHIPS)
  ) compareB (
    .pattern    (patB),
    .patternLen (secondLen_reg),
    .history    (historyNext),
    .match      (matchB)
  );
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      history_reg <= '0;
    end else if (chipValid) begin
      history_reg <= historyNext;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // detection sequence and message end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg        <= ST_HUNT;
      chipCnt_reg      <= 5'h00;
      bitCnt_reg       <= 9'h000;
      chipPhase_reg    <= 1'b0;
      firstIsB_reg     <= 1'b0;
      identifierFound  <= 1'b0;
      secondWasMatched <= 1'b0;
      relockPll        <= 1'b0;
      phaseCorrect     <= 1'b0;
      phaseStep        <= 3'h0;
      payloadValid     <= 1'b0;
      payloadBit       <= 1'b0;
      messageEnd       <= 1'b0;
    end else begin
      identifierFound <= 1'b0;
      relockPll       <= 1'b0;
      phaseCorrect    <= 1'b0;
      payloadValid    <= 1'b0;
      messageEnd      <= 1'b0;
      case (state_reg)
        ST_HUNT: begin
          chipCnt_reg <= 5'h00;
          if (chipValid) begin
            case (scheme)
              SCHEME_SEQ16: begin
                // first B then A; B skipped unless fully configured
                if (bEnabled16 && matchB) begin
                  firstIsB_reg <= 1'b1;
                  state_reg    <= ST_SECOND;
                end else if (!bEnabled16 && matchA) begin
                  identifierFound  <= 1'b1;
                  secondWasMatched <= 1'b0;
                  bitCnt_reg       <= 9'h000;
                  chipPhase_reg    <= 1'b0;
                  state_reg        <= ST_PAYLOAD;
                end
              end
              SCHEME_GAP: begin
                if (matchA) begin
                  firstIsB_reg <= 1'b0;
                  state_reg    <= ST_GAP;
                end
              end
              default: begin
                // parallel; extended also sends the match bit first
                if (matchA || matchB) begin
                  identifierFound  <= 1'b1;
                  secondWasMatched <= !matchA;
                  chipPhase_reg    <= 1'b0;
                  state_reg        <= ST_PAYLOAD;
                  if (scheme == SCHEME_EXTENDED) begin
                    payloadValid <= 1'b1;
                    payloadBit   <= !matchA;
                    bitCnt_reg   <= 9'h001;
                    if (msgEnd_reg[END_LEN_BIT] && payloadLen_reg == 8'h01) begin
                      messageEnd <= 1'b1;
                      state_reg  <= ST_HUNT;
                    end
                  end else begin
                    bitCnt_reg <= 9'h000;
                  end
                end
              end
            endcase
          end
        end
        ST_GAP: begin
          // gap in half bits, one chip per half bit; the gap ends on chip count
          if (chipCnt_reg >= coarseGap) begin
            chipCnt_reg <= 5'h00;
            state_reg   <= ST_SECOND;
            if (scheme_reg[RESYNC_BIT]) begin
              relockPll <= 1'b1;
            end else begin
              phaseCorrect <= 1'b1;
              phaseStep    <= gap_reg[FINE_MSB:0];
            end
          end else if (chipValid) begin
            chipCnt_reg <= chipCnt_reg + 5'h01;
          end
        end
        ST_SECOND: begin
          // second pattern must sit right behind the first, or behind the coarse gap in gap scheme, no sliding search
          if (chipValid) begin
            chipCnt_reg <= chipCnt_reg + 5'h01;
            if (chipCnt_reg + 5'h01 >= (firstIsB_reg ? firstLen_reg : secondLen_reg)) begin
              if (firstIsB_reg ? matchA : matchB) begin
                identifierFound  <= 1'b1;
                secondWasMatched <= 1'b1;
                bitCnt_reg       <= 9'h000;
                chipPhase_reg    <= 1'b0;
                state_reg        <= ST_PAYLOAD;
              end else begin
                state_reg <= ST_HUNT;
              end
            end
          end
        end
        ST_PAYLOAD: begin
          if (endEvent) begin
            messageEnd <= 1'b1;
            state_reg  <= ST_HUNT;
          end else if (chipValid) begin
            chipPhase_reg <= !chipPhase_reg;
            if (chipPhase_reg) begin
              payloadValid <= 1'b1;
              payloadBit   <= chipData;
              bitCnt_reg   <= bitCnt_reg + 9'h001;
              if (msgEnd_reg[END_LEN_BIT] && bitCnt_reg + 9'h001 >= lengthLimit) begin
                messageEnd <= 1'b1;
                state_reg  <= ST_HUNT;
              end
            end
          end
        end
        default: begin
          state_reg <= ST_HUNT;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- tb/match_checker.sv ----
// port-level assertions for the start identifier matcher
`default_nettype none
module match_checker #(
  parameter int CHIPS = 16
) (
  // clock and reset
  input wire logic                           clk,
  input wire logic                           rst,
  // register bus
  input wire start_identifier_pkg::axi_req_t axiReq,
  input wire start_identifier_pkg::axi_rsp_t axiRsp,
  // stream and results
  input wire logic                           chipValid,
  input wire logic                           chipData,
  input wire logic                           syncLoss,
  input wire logic                           codeViolation,
  input wire logic                           identifierFound,
  input wire logic                           secondWasMatched,
  input wire logic                           relockPll,
  input wire logic                           phaseCorrect,
  input wire logic [2:0]                     phaseStep,
  input wire logic                           payloadValid,
  input wire logic                           payloadBit,
  input wire logic                           messageEnd
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  bresp_hold_a: assert property (axiRsp.bvalid && !axiReq.bready
    |=> axiRsp.bvalid && $stable(axiRsp.bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (axiRsp.rvalid && !axiReq.rready
    |=> axiRsp.rvalid && $stable(axiRsp.rdata)) else $error("read answer dropped");
  write_answer_a: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid
    && axiRsp.wready |-> ##[1:2] axiRsp.bvalid) else $error("no write answer");
  read_answer_a: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("no read answer");
  busy_refuse_a: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
    else $error("write taken while answer pending");
  found_by_chip_a: assert property (
    identifierFound |-> $past(chipValid) ##1 !identifierFound) else $error("bad found pulse");
  payload_by_chip_a: assert property (
    payloadValid && !identifierFound |-> $past(chipValid)) else $error("bit without chip");
  bit_pace_a: assert property (payloadValid |=> !payloadValid)
    else $error("payload bits too close");
  end_then_idle_a: assert property (messageEnd |=> !payloadValid && !messageEnd)
    else $error("activity after message end");
  gap_exclusive_a: assert property (relockPll || phaseCorrect
    |-> !(relockPll && phaseCorrect) && !payloadValid) else $error("both gap actions");
  ////////////////////////////////////////////////////////////////
  found_c: cover property (identifierFound);
  end_c: cover property (messageEnd);
  relock_c: cover property (relockPll);
  phase_c: cover property (phaseCorrect);
endmodule

bind start_pattern_match_eom_cfg match_checker #(.CHIPS(CHIPS)) checker_i (
  .clk(clk), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp), .chipValid(chipValid),
  .chipData(chipData), .syncLoss(syncLoss), .codeViolation(codeViolation),
  .identifierFound(identifierFound), .secondWasMatched(secondWasMatched),
  .relockPll(relockPll), .phaseCorrect(phaseCorrect), .phaseStep(phaseStep),
  .payloadValid(payloadValid), .payloadBit(payloadBit), .messageEnd(messageEnd));
`default_nettype wire

// ---- tb/chip_source.sv ----
// behavioural recovered chip stream feeding the matcher
`default_nettype none
module chip_source (
  // clock
  input  wire logic clk,
  // chip stream
  output var logic  chipValid,
  output var logic  chipData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    chipValid = 1'b0;
    chipData  = 1'b0;
  end
  // last chip sent is chip 0, the newest in the history
  task automatic send(input logic [31:0] word, input int n, input bit slow);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      chipValid <= 1'b1;
      chipData  <= word[i];
      if (slow) begin
        @(posedge clk);
        chipValid <= 1'b0;
        chipData  <= ~word[i];
      end
    end
    @(posedge clk);
    chipValid <= 1'b0;
    // inverted so a stale chip cannot pass for a real one
    chipData  <= ~word[0];
  endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the start identifier matcher
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import start_identifier_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  axi_req_t axiReq = '0;
  axi_rsp_t axiRsp;
  logic chipValid, chipData, identifierFound, secondWasMatched, relockPll;
  logic phaseCorrect, payloadValid, payloadBit, messageEnd;
  logic syncLoss = 1'b0;
  logic codeViolation = 1'b0;
  logic [2:0] phaseStep;
  int bad_count = 0;
  int cmp_count = 0;
  // counts of found, end, payload bit, relock, phase pulses
  int cnt [5];
  logic swm;
  logic [7:0] pbits;
  logic [31:0] q;
  logic [1:0] rs;
  start_pattern_match_eom_cfg #(.CHIPS(16)) dut (
    .clk(clk), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp), .chipValid(chipValid),
    .chipData(chipData), .syncLoss(syncLoss), .codeViolation(codeViolation),
    .identifierFound(identifierFound), .secondWasMatched(secondWasMatched),
    .relockPll(relockPll), .phaseCorrect(phaseCorrect), .phaseStep(phaseStep),
    .payloadValid(payloadValid), .payloadBit(payloadBit), .messageEnd(messageEnd));
  chip_source src (.clk(clk), .chipValid(chipValid), .chipData(chipData));
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  // pulses are sampled mid-cycle, away from the launching edge
  always @(negedge clk) begin
    cnt[0] += (identifierFound === 1'b1);
    cnt[1] += (messageEnd === 1'b1);
    cnt[2] += (payloadValid === 1'b1);
    cnt[3] += (relockPll === 1'b1);
    cnt[4] += (phaseCorrect === 1'b1);
    if (identifierFound === 1'b1) swm = secondWasMatched;
    if (payloadValid === 1'b1) pbits = {pbits[6:0], payloadBit};
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input bit wr, input logic [9:0] idx, input logic [7:0] d);
    bit a, w, r, b;
    @(posedge clk);
    axiReq.awaddr  <= {idx, 2'b00};
    axiReq.araddr  <= {idx, 2'b00};
    axiReq.wdata   <= {24'h0, d};
    axiReq.wstrb   <= 4'hf;
    axiReq.awvalid <= wr;
    axiReq.wvalid  <= wr;
    axiReq.bready  <= wr;
    axiReq.arvalid <= !wr;
    axiReq.rready  <= !wr;
    do begin
      @(negedge clk);
      a = axiReq.awvalid & axiRsp.awready;
      w = axiReq.wvalid & axiRsp.wready;
      r = axiReq.arvalid & axiRsp.arready;
      b = wr ? axiRsp.bvalid : axiRsp.rvalid;
      rs = wr ? axiRsp.bresp : axiRsp.rresp;
      q = axiRsp.rdata;
      @(posedge clk);
      if (a) axiReq.awvalid <= 1'b0;
      if (w) axiReq.wvalid <= 1'b0;
      if (r) axiReq.arvalid <= 1'b0;
      if (b) axiReq.bready <= 1'b0;
      if (b) axiReq.rready <= 1'b0;
    end while (!b);
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
    chk(rs, RESP_OKAY);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(rs, RESP_OKAY);
    chk(q, {24'h0, e});
  endtask
  task automatic settle;
    repeat (4) @(negedge clk);
  endtask
  task automatic pulse(input bit sync);
    @(posedge clk);
    if (sync) syncLoss <= 1'b1;
    else codeViolation <= 1'b1;
    @(posedge clk);
    syncLoss <= 1'b0;
    codeViolation <= 1'b0;
  endtask
  task automatic setup(input logic [7:0] lenA, input logic [7:0] mode, input logic [7:0] plen);
    wr(IDX_FIRST_LEN, lenA);
    wr(IDX_SCHEME, mode);
    wr(IDX_PAYLOAD_LEN, plen);
    cnt = '{default: 0};
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(IDX_MSG_END, 8'h05);
    rd(IDX_FIRST_LEN, 8'h00);
    rd(IDX_SECOND_LEN, 8'h00);
    rd(IDX_GAP, 8'h00);
    bus(1'b1, 10'h0ff, 8'h11);
    chk(rs, RESP_SLVERR);
    wr(IDX_FIRST_LO, 8'hb4);
    wr(IDX_FIRST_HI, 8'h5a);
    wr(IDX_SECOND_LO, 8'h3c);
    wr(IDX_SECOND_LEN, 8'h08);
  endtask
  task automatic t_parallel(input bit useB);
    setup(8'h08, 8'h81, 8'h02);
    src.send(useB ? 32'h3c : 32'hb4, 8, useB);
    src.send(32'h6, 4, 1'b0);
    settle;
    chk(cnt[0], 1);
    chk(swm, useB);
    chk(pbits[1:0], 2'b10);
    chk(cnt[2], 2);
    chk(cnt[1], 1);
  endtask
  task automatic t_gap(input bit resync);
    setup(8'h08, resync ? 8'h82 : 8'h02, 8'h01);
    wr(IDX_GAP, 8'h15);
    src.send(32'hb4, 8, 1'b0);
    src.send(32'h3, 2, 1'b1);
    src.send(32'h3c, 8, 1'b0);
    src.send(32'h1, 2, 1'b0);
    settle;
    chk(cnt[0], 1);
    chk(swm, 1);
    chk(cnt[3], resync);
    chk(cnt[4], !resync);
    chk(phaseStep, resync ? 3'h0 : 3'h5);
    chk(cnt[1], 1);
  endtask
  task automatic t_ends;
    setup(8'h08, 8'h81, 8'h00);
    src.send(32'hb4, 8, 1'b0);
    src.send(32'h6, 4, 1'b0);
    pulse(1'b0);
    settle;
    chk(cnt[1], 0);
    pulse(1'b1);
    settle;
    chk(cnt[1], 1);
    wr(IDX_MSG_END, 8'h02);
    src.send(32'hb4, 8, 1'b0);
    pulse(1'b1);
    settle;
    chk(cnt[1], 1);
    pulse(1'b0);
    settle;
    chk(cnt[1], 2);
    wr(IDX_MSG_END, 8'h05);
  endtask
  task automatic t_ext;
    setup(8'h08, 8'h83, 8'h01);
    src.send(32'h3c, 8, 1'b0);
    settle;
    chk(pbits[0], 1);
    chk(cnt[2], 1);
    chk(cnt[1], 1);
  endtask
  task automatic t_seq16;
    setup(8'h10, 8'h80, 8'h01);
    src.send(32'h3c, 8, 1'b0);
    src.send(32'h5ab4, 16, 1'b0);
    src.send(32'h1, 2, 1'b0);
    settle;
    chk(cnt[0], 1);
    chk(cnt[1], 1);
  endtask
  task automatic summarize;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_parallel(1'b0);
    t_parallel(1'b1);
    t_gap(1'b1);
    t_gap(1'b0);
    t_ends;
    t_ext;
    t_seq16;
    summarize;
  end
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    summarize;
  end
endmodule
`default_nettype wire
